/* File: verilog/aie_pkg.sv */
// Constants and types shared by the add execution datapath.
package aie_pkg;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned INSTR_W = 16;
  localparam int unsigned FILE_AW = 8;
  localparam int unsigned APB_AW = 8;
  localparam int unsigned APB_DW = 32;

  localparam logic [APB_AW-1:0] OFF_INSTR = 8'h00;
  localparam logic [APB_AW-1:0] OFF_ACC = 8'h04;
  localparam logic [APB_AW-1:0] OFF_STATUS = 8'h08;
  localparam logic [APB_AW-1:0] OFF_MEMADDR = 8'h0c;
  localparam logic [APB_AW-1:0] OFF_MEMDATA = 8'h10;

  localparam int unsigned ST_CARRY = 0;
  localparam int unsigned ST_DIGIT = 1;
  localparam int unsigned ST_ZERO = 2;
  localparam int unsigned ST_OVF = 3;
  localparam int unsigned ST_BUSY = 4;
  localparam int unsigned ST_ILLEGAL = 5;

  localparam logic [7:0] OPC_ADD_LIT = 8'hb1;
  localparam logic [6:0] OPC_ADD_FILE = 7'h07;
  localparam int unsigned DEST_BIT = 8;

  localparam logic [DATA_W-1:0] ACC_RST = 8'h00;
  localparam logic [INSTR_W-1:0] INSTR_RST = 16'h0000;
  localparam logic [FILE_AW-1:0] MEMADDR_RST = 8'h00;

  typedef enum logic [2:0] {PH_IDLE, PH_DECODE, PH_READ, PH_EXEC, PH_WRITE} aie_phase_e;
  typedef enum logic [1:0] {OP_NOP, OP_LIT, OP_FILE} aie_op_e;
endpackage

/* File: verilog/aie_mem_if.sv */
// Port bundle between the datapath and its file register memory.
`timescale 1ns/1ps
interface aie_mem_if #(
  parameter int unsigned AW = 8,
  parameter int unsigned DW = 8
);
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata;
  logic we;
  logic [DW-1:0] rdata;

  modport core (output addr, output wdata, output we, input rdata);
  modport mem (input addr, input wdata, input we, output rdata);
endinterface

/* File: verilog/aie_file_mem.sv */
// File register memory with a registered read port.
`timescale 1ns/1ps
module aie_file_mem #(
  parameter int unsigned AW = 8,
  parameter int unsigned DW = 8
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // Memory port
  aie_mem_if.mem port
);
  logic [DW-1:0] mem_q [2**AW];
  logic [DW-1:0] rdata_q;

  always_ff @(posedge sys_clk_i) begin
    if (port.we) begin
      mem_q[port.addr] <= port.wdata;
    end
  end

  // Read data is the old content when a write hits the same word.
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= mem_q[port.addr];
    end
  end

  assign port.rdata = rdata_q;
endmodule

/* File: verilog/aie_add_exec.sv */
// Add instruction execution datapath with APB register access.
`timescale 1ns/1ps
// Operation
// - Literal add into accumulator, update flags
// - Upper byte b1 selects literal add
// - Top bits 0000111 select file add
// - Destination clear writes accumulator only
// - Destination set writes file register only
// - Four phases: decode, read, execute, write
module aie_add_exec
  import aie_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [APB_AW-1:0] paddr_i,
  input wire logic [APB_DW-1:0] pwdata_i,
  output logic [APB_DW-1:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Status
  output logic busy_o,
  output logic [2:0] cycle_phases_o
);
  aie_phase_e phase_q;
  aie_phase_e phase_d;
  aie_op_e op_q;
  logic [INSTR_W-1:0] instr_q;
  logic [DATA_W-1:0] accumulator_register_q;
  logic [DATA_W-1:0] result_q;
  logic [FILE_AW-1:0] memaddr_q;
  logic carry_q;
  logic digit_carry_flag_q;
  logic zero_q;
  logic overflow_flag_q;
  logic illegal_q;
  logic [3:0] flags_pend_q;
  logic pready_q;
  logic pslverr_q;
  logic [APB_DW-1:0] prdata_q;
  logic busy_q;

  aie_mem_if #(.AW(FILE_AW), .DW(DATA_W)) mem_bus ();

  aie_file_mem #(.AW(FILE_AW), .DW(DATA_W)) u_file_mem (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .port(mem_bus.mem)
  );

  function automatic aie_op_e decode_op(input logic [INSTR_W-1:0] ins);
    aie_op_e op;
    op = OP_NOP;
    if (ins[15:8] == OPC_ADD_LIT) begin
      op = OP_LIT;
    end else if (ins[15:9] == OPC_ADD_FILE) begin
      op = OP_FILE;
    end
    return op;
  endfunction

  // Bus decode.
  wire busy = (phase_q != PH_IDLE);
  wire first_access = psel_i && penable_i && !pready_q;
  wire fire = psel_i && penable_i && pready_q && !pslverr_q;
  wire wr_fire = fire && pwrite_i;
  wire hit_instr = (paddr_i == OFF_INSTR);
  wire hit_acc = (paddr_i == OFF_ACC);
  wire hit_status = (paddr_i == OFF_STATUS);
  wire hit_memaddr = (paddr_i == OFF_MEMADDR);
  wire hit_memdata = (paddr_i == OFF_MEMDATA);
  wire mapped = hit_instr || hit_acc || hit_status || hit_memaddr || hit_memdata;
  // While an instruction runs, the memory port and the accumulator belong to it.
  wire busy_err = busy && (hit_memdata || (pwrite_i && !hit_memaddr));
  wire acc_err = !mapped || busy_err;
  wire issue = wr_fire && hit_instr;

  wire [7:0] status_w = {2'b00, illegal_q, busy, overflow_flag_q, zero_q,
                         digit_carry_flag_q, carry_q};
  wire [APB_DW-1:0] rd_mux =
    hit_instr ? {16'h0000, instr_q} :
    hit_acc ? {24'h000000, accumulator_register_q} :
    hit_status ? {24'h000000, status_w} :
    hit_memaddr ? {24'h000000, memaddr_q} :
    hit_memdata ? {24'h000000, mem_bus.rdata} : 32'h00000000;

  // Adder and flags.
  wire [DATA_W-1:0] operand_w = (op_q == OP_LIT) ? instr_q[7:0] : mem_bus.rdata;
  wire [DATA_W:0] sum_w = {1'b0, accumulator_register_q} + {1'b0, operand_w};
  wire [4:0] low_sum_w = {1'b0, accumulator_register_q[3:0]} + {1'b0, operand_w[3:0]};
  wire carry_w = sum_w[DATA_W];
  wire digit_w = low_sum_w[4];
  wire zero_w = (sum_w[DATA_W-1:0] == 8'h00);
  wire ovf_w = (accumulator_register_q[7] == operand_w[7]) &&
               (sum_w[7] != accumulator_register_q[7]);
  wire dest_file = instr_q[DEST_BIT];
  wire core_we = (phase_q == PH_WRITE) && (op_q == OP_FILE) && dest_file;
  wire acc_we = (phase_q == PH_WRITE) && ((op_q == OP_LIT) ||
                ((op_q == OP_FILE) && !dest_file));

  assign mem_bus.addr = busy ? instr_q[7:0] : memaddr_q;
  assign mem_bus.we = core_we || (wr_fire && hit_memdata);
  assign mem_bus.wdata = core_we ? result_q : pwdata_i[7:0];

  // Phase sequencer; a NOP still walks all four phases.
  always_comb begin
    phase_d = phase_q;
    unique case (phase_q)
      PH_IDLE: begin
        if (issue) begin
          phase_d = PH_DECODE;
        end
      end
      PH_DECODE: phase_d = PH_READ;
      PH_READ: phase_d = PH_EXEC;
      PH_EXEC: phase_d = PH_WRITE;
      PH_WRITE: phase_d = PH_IDLE;
      default: phase_d = PH_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      phase_q <= PH_IDLE;
      op_q <= OP_NOP;
    end else begin
      phase_q <= phase_d;
      if (phase_q == PH_DECODE) begin
        op_q <= decode_op(instr_q);
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      result_q <= '0;
      flags_pend_q <= '0;
    end else if (phase_q == PH_EXEC) begin
      result_q <= sum_w[DATA_W-1:0];
      flags_pend_q <= {ovf_w, zero_w, digit_w, carry_w};
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      accumulator_register_q <= ACC_RST;
    end else if (acc_we) begin
      accumulator_register_q <= result_q;
    end else if (wr_fire && hit_acc) begin
      accumulator_register_q <= pwdata_i[7:0];
    end
  end

  // The instruction writes the flags in the write phase only when op_q is not OP_NOP, so a NOP leaves them alone.
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      {overflow_flag_q, zero_q, digit_carry_flag_q, carry_q} <= 4'h0;
    end else if ((phase_q == PH_WRITE) && (op_q != OP_NOP)) begin
      {overflow_flag_q, zero_q, digit_carry_flag_q, carry_q} <= flags_pend_q;
    end else if (wr_fire && hit_status) begin
      {overflow_flag_q, zero_q, digit_carry_flag_q, carry_q} <= pwdata_i[3:0];
    end
  end

  // Set wins over a software clear in the same cycle.
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      illegal_q <= 1'b0;
    end else if ((phase_q == PH_DECODE) && (decode_op(instr_q) == OP_NOP)) begin
      illegal_q <= 1'b1;
    end else if (wr_fire && hit_status && pwdata_i[ST_ILLEGAL]) begin
      illegal_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      instr_q <= INSTR_RST;
      memaddr_q <= MEMADDR_RST;
    end else begin
      if (issue) begin
        instr_q <= pwdata_i[INSTR_W-1:0];
      end
      if (wr_fire && hit_memaddr) begin
        memaddr_q <= pwdata_i[FILE_AW-1:0];
      end
    end
  end

  // Every transfer takes one wait state so that memory data are registered.
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
      busy_q <= 1'b0;
    end else begin
      pready_q <= first_access;
      pslverr_q <= first_access && acc_err;
      prdata_q <= (first_access && !pwrite_i && !acc_err) ? rd_mux : 32'h00000000;
      busy_q <= (phase_d != PH_IDLE);
    end
  end

  assign prdata_o = prdata_q;
  assign pready_o = pready_q;
  assign pslverr_o = pslverr_q;
  assign busy_o = busy_q;
  assign cycle_phases_o = phase_q;

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (sys_rst_i);

  a_lit_acc_sum:
    assert property ((phase_q == PH_EXEC) && (op_q == OP_LIT) |-> ##2
      accumulator_register_q == $past(sum_w[DATA_W-1:0], 2))
    else $error("Literal add did not reach the accumulator.");

  a_lit_decode:
    assert property ((phase_q == PH_DECODE) && (instr_q[15:8] == 8'hb1) |=> op_q == OP_LIT)
    else $error("Literal add opcode not decoded.");

  a_file_decode:
    assert property ((phase_q == PH_DECODE) && (instr_q[15:9] == 7'h07) |=> op_q == OP_FILE)
    else $error("File add opcode not decoded.");

  a_dest_acc_only:
    assert property ((phase_q == PH_WRITE) && (op_q == OP_FILE) && !instr_q[8] |->
      !mem_bus.we ##1 accumulator_register_q == $past(result_q))
    else $error("Clear destination touched the file register.");

  a_dest_file_only:
    assert property ((phase_q == PH_WRITE) && (op_q == OP_FILE) && instr_q[8] |->
      mem_bus.we && (mem_bus.wdata == result_q) ##1 $stable(accumulator_register_q))
    else $error("Set destination did not write the file register alone.");

  a_phase_order:
    assert property ((phase_q == PH_DECODE) |=> (phase_q == PH_READ) ##1
      (phase_q == PH_EXEC) ##1 (phase_q == PH_WRITE) ##1 (phase_q == PH_IDLE))
    else $error("Instruction phases out of order.");

  a_flag_values:
    assert property ((phase_q == PH_EXEC) && (op_q != OP_NOP) |-> ##2
      (carry_q == $past(carry_w, 2)) && (digit_carry_flag_q == $past(digit_w, 2)) &&
      (zero_q == $past(zero_w, 2)) && (overflow_flag_q == $past(ovf_w, 2)))
    else $error("Flags do not match the executed sum.");

  // Bus and phase guards; a refused transfer must never reach the datapath.
  // A running instruction owns the accumulator, the memory port and the instruction word.

  a_ready_wait:
    assert property (psel_i && penable_i && !pready_o |=> pready_o)
    else $error("Access cycle was not answered after one wait state.");

  a_ready_pulse:
    assert property (pready_o |=> !pready_o)
    else $error("Ready stood for more than one cycle.");

  a_error_with_ready:
    assert property (pslverr_o |-> pready_o)
    else $error("Slave error shown without ready.");

  a_rdata_idle:
    assert property (!pready_o |-> (prdata_o == 32'h00000000))
    else $error("Read data not zero outside the answer cycle.");

  a_busy_phase:
    assert property (busy_o == (phase_q != PH_IDLE))
    else $error("Busy does not follow the instruction phases.");

  a_phase_start:
    assert property (issue |=> (phase_q == PH_DECODE))
    else $error("Instruction write did not start the decode phase.");

  a_instr_held:
    assert property ((phase_q != PH_IDLE) |=> $stable(instr_q))
    else $error("Instruction word changed while it ran.");

  a_acc_held:
    assert property ((phase_q != PH_IDLE) && (phase_q != PH_WRITE) |=>
      $stable(accumulator_register_q))
    else $error("Accumulator changed before the write phase.");

  a_mem_quiet:
    assert property ((phase_q != PH_IDLE) && (phase_q != PH_WRITE) |-> !mem_bus.we)
    else $error("File register written before the write phase.");

  a_lit_no_file:
    assert property ((phase_q == PH_WRITE) && (op_q == OP_LIT) |-> !mem_bus.we)
    else $error("Literal add wrote the file register.");

  a_file_read_addr:
    assert property ((phase_q == PH_READ) && (op_q == OP_FILE) |->
      (mem_bus.addr == instr_q[FILE_AW-1:0]))
    else $error("File add read the wrong file register.");

  a_nop_flags_kept:
    assert property ((phase_q == PH_WRITE) && (op_q == OP_NOP) |=>
      $stable({overflow_flag_q, zero_q, digit_carry_flag_q, carry_q}))
    else $error("Unknown opcode changed the flags.");

  a_illegal_set:
    assert property ((phase_q == PH_DECODE) && (decode_op(instr_q) == OP_NOP) |=> illegal_q)
    else $error("Unknown opcode did not raise the illegal flag.");
endmodule

/* File: tb/add_instruction_exec_tb.sv */
// Self-checking bench for the add execution datapath.
`timescale 1ns/1ps
`define CHK(n, e, s) begin checks++; if ((e) !== (s)) begin errors++; \
  $display("unexpected %s exp %0h got %0h", n, e, s); end end
module add_instruction_exec_tb;
  import aie_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] padr = 8'h00;
  logic [31:0] pwd = 32'h0;
  logic [31:0] seed = 32'hec29;
  logic [31:0] prd, rd;
  logic rdy, serr, err, busy;
  logic [2:0] ph;
  int errors = 0;
  int checks = 0;
  int cyc = 0;
  int acc, fc, fdc, fz, fov, fill, a, k, f, r;
  int mem [256];
  aie_add_exec i_aie_add_exec (.sys_clk_i(clk), .sys_rst_i(rst), .psel_i(psel),
    .penable_i(pen), .pwrite_i(pwr), .paddr_i(padr), .pwdata_i(pwd), .prdata_o(prd),
    .pready_o(rdy), .pslverr_o(serr), .busy_o(busy), .cycle_phases_o(ph));
  always #20 clk = ~clk;
  // A hang anywhere ends the run as a mismatch.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  function automatic logic [31:0] nxt();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction
  function automatic int addm(int x, int y);
    r = x + y;
    fc = (r >> 8) & 1;
    fdc = ((x & 15) + (y & 15)) > 15;
    fz = (r & 255) == 0;
    fov = ((x ^ r) & (y ^ r) & 128) != 0;
    return r & 255;
  endfunction
  // The request stands until pready is seen high at a rising edge; the answer is taken there.
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    padr <= ad;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (rdy !== 1'b1);
    rd = prd;
    err = serr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] ad, input int e, input string nm);
    apb(1'b0, ad, 32'h0);
    `CHK(nm, 32'(e), rd)
    `CHK("read error", 1'b0, err)
  endtask
  task automatic stchk();
    rdchk(OFF_STATUS, fill * 32 + fov * 8 + fz * 4 + fdc * 2 + fc, "status");
  endtask
  task automatic run(input logic [15:0] ins, input bit q);
    apb(1'b1, OFF_INSTR, {16'h0, ins});
    for (int p = 1; p < 6 && q; p++) begin
      @(negedge clk);
      `CHK("phase", 3'(p % 5), ph)
      `CHK("busy", p < 5, busy)
    end
    if (ins[15:8] == 8'hb1) acc = addm(acc, ins[7:0]);
    else if (ins[15:9] == 7'h07 && ins[8]) mem[ins[7:0]] = addm(acc, mem[ins[7:0]]);
    else if (ins[15:9] == 7'h07) acc = addm(acc, mem[ins[7:0]]);
    else fill = 1;
  endtask
  initial begin
    fc = 0;
    fdc = 0;
    fz = 0;
    fov = 0;
    fill = 0;
    acc = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rdchk(OFF_ACC, 0, "acc");
    stchk();
    rdchk(OFF_MEMADDR, 0, "memaddr");
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      a = (i == 0) ? 128 : nxt() & 255;
      k = (i == 0) ? 128 : nxt() & 255;
      apb(1'b1, OFF_ACC, 32'(a));
      acc = a;
      run(16'hb100 | 16'(k), 1'b1);
      rdchk(OFF_ACC, acc, "acc");
      stchk();
    end
    $display("test literal done");
    for (int i = 0; i < 8; i++) begin
      f = (i == 0) ? 255 : nxt() & 255;
      a = nxt() & 255;
      k = nxt() & 255;
      apb(1'b1, OFF_MEMADDR, 32'(f));
      apb(1'b1, OFF_MEMDATA, 32'(k));
      apb(1'b1, OFF_ACC, 32'(a));
      acc = a;
      mem[f] = k;
      run(16'h0e00 | 16'(i % 2 * 256 + f), 1'b1);
      rdchk(OFF_ACC, acc, "acc");
      rdchk(OFF_MEMDATA, mem[f], "file");
      stchk();
    end
    $display("test file done");
    run(16'h0000, 1'b1);
    stchk();
    apb(1'b1, OFF_STATUS, 32'h20);
    fill = 0;
    fc = 0;
    fdc = 0;
    fz = 0;
    fov = 0;
    stchk();
    $display("test illegal done");
    run(16'hb1ff, 1'b0);
    apb(1'b1, OFF_MEMDATA, 32'h0);
    `CHK("busy refusal", 1'b1, err)
    apb(1'b0, 8'h14, 32'h0);
    `CHK("unmapped err", 1'b1, err)
    `CHK("unmapped data", 32'h0, rd)
    rdchk(OFF_MEMDATA, mem[f], "refused file");
    rdchk(OFF_ACC, acc, "acc");
    stchk();
    $display("test refusal done");
    stop_test();
  end
endmodule
